// *** event_pin_resolver.v ***
`timescale 1ns/100ps
`include "pin_port_map.vh"

// ------------------------------------------------------------
// per-pin merge of simultaneous event pulses
// ------------------------------------------------------------
// fixed priority: set over clear over toggle
module event_pin_resolver
(
	input  wire       cur_level,
	input  wire       hit_set,
	input  wire       hit_clear,
	input  wire       hit_toggle,
	output wire       apply,
	output wire       new_level
);

	assign apply     = hit_set | hit_clear | hit_toggle;
	assign new_level = hit_set   ? 1'b1 :
	                   hit_clear ? 1'b0 :
	                   ~cur_level;

endmodule

// *** pad_event_source.sv ***
`timescale 1ns/100ps

module pad_event_source
(
	input  wire        mclk,
	input  wire [31:0] pad_out,
	input  wire [31:0] pad_oe,
	output reg  [3:0]  event_in,
	output wire [31:0] pad_in
);
	reg [31:0] drift = 32'h5A5A5A5A;

	// undriven pads wander so a stale level never reads back
	always @(posedge mclk)
		drift <= ~drift;
	assign pad_in = (pad_out & pad_oe) | (drift & ~pad_oe);

	initial
		event_in = 4'h0;

	// events live in another domain, so edges land off the clock
	task put(input [3:0] m);
	begin
		#3.3;
		event_in = m;
	end
	endtask
endmodule

// *** pin_port_map.vh ***
`ifndef PIN_PORT_MAP_VH
`define PIN_PORT_MAP_VH

// ------------------------------------------------------------
// port geometry
// ------------------------------------------------------------
`define NUM_PINS        32
`define PIN_IDX_W       5
`define NUM_EVENTS      4
`define FUNC_SEL_W      4
`define ANALOG_FUNC     4'h1

// ------------------------------------------------------------
// pad configuration field positions
// ------------------------------------------------------------
`define CFG_W           3
`define CFG_FUNC_EN     0
`define CFG_INPUT_EN    1
`define CFG_PULL_EN     2

// ------------------------------------------------------------
// software write operations
// ------------------------------------------------------------
`define OP_W            2
`define OP_WRITE        2'h0
`define OP_SET          2'h1
`define OP_CLEAR        2'h2
`define OP_TOGGLE       2'h3

// ------------------------------------------------------------
// event actions
// ------------------------------------------------------------
`define ACT_W           2
`define ACT_OUTPUT      2'h0
`define ACT_SET         2'h1
`define ACT_CLEAR       2'h2
`define ACT_TOGGLE      2'h3

// ------------------------------------------------------------
// reset values and timing
// ------------------------------------------------------------
`define RST_WORD        32'h00000000
`define RST_CFG         3'h0
`define RST_FUNC        4'h0
`define RST_EVENT_INPUT_CONTROL      8'h00
`define EVT_LATENCY_MAX 3

`endif

// *** secure_pin_port_events.v ***
// Function
// - non-secure writes to drive-enable or level ignored for secure pins
// - non-secure pad config or function writes blocked for secure pins
// - non-secure reads of secure pin bits return zero, no error
// - check flag sets while shadow and attribute registers differ
// - writing one clears check flag and deasserts port interrupt
// - analog function selection disables pad digital features
// - accept events possibly from another clock domain to control pins
// - output action makes pin follow event level
// - set, clear, toggle actions act on each detected event
// - output action no latency; others within three cycles of edge
// - action field per input; enable bit one enables, zero disables
// - every enabled action carried out for any incoming event
// - each event input targets exactly one pin by its select field
// - up to four events per pin yield one resulting action
// - reset leaves all lines input, buffers and pulls disabled
// - core-local pad bus accesses win; peripheral bus waits a cycle
// - each pin has security attribute; only secure reaches secured pins
`timescale 1ns/100ps
`include "pin_port_map.vh"

module secure_pin_port_events
(
	input  wire                       mclk,
	input  wire                       reset,
	// peripheral bus access
	input  wire                       apb_req,
	input  wire                       apb_secure,
	input  wire                       apb_write,
	input  wire [3:0]                 apb_sel,
	input  wire [1:0]                 apb_op,
	input  wire [31:0]                apb_wdata,
	input  wire [4:0]                 apb_pin,
	output wire                       apb_ready,
	output reg  [31:0]                apb_rdata,
	// core-local pad bus access
	input  wire                       lpb_req,
	input  wire                       lpb_secure,
	input  wire                       lpb_write,
	input  wire [3:0]                 lpb_sel,
	input  wire [1:0]                 lpb_op,
	input  wire [31:0]                lpb_wdata,
	input  wire [4:0]                 lpb_pin,
	output reg  [31:0]                lpb_rdata,
	// events
	input  wire [3:0]                 event_in,
	input  wire [31:0]                event_input_control,
	// pads
	input  wire [31:0]                pad_in,
	output wire [31:0]                pad_out,
	output wire [31:0]                pad_oe,
	output wire [31:0]                pad_input_en,
	output wire [31:0]                pad_pull_en,
	output wire [31:0]                pad_analog,
	output reg  [127:0]               pad_function_select,
	output wire                       port_irq,
	output reg                        irq_flag_reg
);

	// ------------------------------------------------------------
	// target selects
	// ------------------------------------------------------------
	localparam SEL_DIR    = 4'h0;
	localparam SEL_LEVEL  = 4'h1;
	localparam SEL_IN     = 4'h2;
	localparam SEL_ATTR   = 4'h3;
	localparam SEL_SHADOW = 4'h4;
	localparam SEL_CFG    = 4'h5;
	localparam SEL_FUNC   = 4'h6;
	localparam SEL_BULK   = 4'h7;
	localparam SEL_FLAG   = 4'h8;
	localparam SEL_IRQEN  = 4'h9;

	reg  [31:0]  drive_enable;
	reg  [31:0]  level;
	reg  [31:0]  pad_security_attr;
	reg  [31:0]  security_shadow_copy;
	reg  [95:0]  pad_config_reg;
	reg          irq_enable;
	reg  [31:0]  sample;
	reg  [3:0]   ev_s1;
	reg  [3:0]   ev_s2;
	reg  [3:0]   ev_s3;

	// ------------------------------------------------------------
	// bus arbitration
	// ------------------------------------------------------------
	wire        use_lpb = lpb_req;
	wire        acc_req = lpb_req | apb_req;
	wire        sec     = use_lpb ? lpb_secure : apb_secure;
	wire        wr      = use_lpb ? lpb_write : apb_write;
	wire [3:0]  sel     = use_lpb ? lpb_sel : apb_sel;
	wire [1:0]  op      = use_lpb ? lpb_op : apb_op;
	wire [31:0] wdata   = use_lpb ? lpb_wdata : apb_wdata;
	wire [4:0]  pin     = use_lpb ? lpb_pin : apb_pin;
	assign apb_ready = ~lpb_req;

	// secure masters see every pin, others only non-secure ones
	wire [31:0] vis     = sec ? 32'hFFFFFFFF : pad_security_attr;
	wire        pin_ok  = sec | pad_security_attr[pin];
	wire        do_wr   = acc_req & wr;

	function [31:0] apply_op;
		input [31:0] cur;
		input [31:0] val;
		input [1:0]  kind;
		input [31:0] mask;
		reg   [31:0] res;
		begin
			res = cur;
			case (kind)
				`OP_WRITE:  res = val;
				`OP_SET:    res = cur | val;
				`OP_CLEAR:  res = cur & ~val;
				`OP_TOGGLE: res = cur ^ val;
				default:    res = cur;
			endcase
			apply_op = (res & mask) | (cur & ~mask);
		end
	endfunction

	// ------------------------------------------------------------
	// event path
	// ------------------------------------------------------------
	// s1 only feeds s2; edge detect uses s2/s3
	always @(posedge mclk)
	begin
		if (reset)
		begin
			ev_s1 <= 4'h0;
			ev_s2 <= 4'h0;
			ev_s3 <= 4'h0;
		end
		else
		begin
			ev_s1 <= event_in;
			ev_s2 <= ev_s1;
			ev_s3 <= ev_s2;
		end
	end

	wire [3:0]  ev_rise = ev_s2 & ~ev_s3;
	reg  [31:0] hit_set;
	reg  [31:0] hit_clear;
	reg  [31:0] hit_toggle;
	reg  [31:0] follow_en;
	reg  [31:0] follow_val;
	integer     e;

	always @*
	begin
		hit_set    = 32'h0;
		hit_clear  = 32'h0;
		hit_toggle = 32'h0;
		follow_en  = 32'h0;
		follow_val = 32'h0;
		for (e = 0; e < `NUM_EVENTS; e = e + 1)
		begin
			// [7:6] action, [5] enable, [4:0] pin per input byte
			if (event_input_control[e*8+5])
			begin
				case (event_input_control[e*8+6 +: 2])
					`ACT_OUTPUT:
					begin
						follow_en[event_input_control[e*8 +: 5]] = 1'b1;
						follow_val[event_input_control[e*8 +: 5]] = event_in[e];
					end
					// or-merge: a quiet input must not mask a busy one
					`ACT_SET:
						hit_set[event_input_control[e*8 +: 5]] =
							hit_set[event_input_control[e*8 +: 5]] | ev_rise[e];
					`ACT_CLEAR:
						hit_clear[event_input_control[e*8 +: 5]] =
							hit_clear[event_input_control[e*8 +: 5]] | ev_rise[e];
					`ACT_TOGGLE:
						hit_toggle[event_input_control[e*8 +: 5]] =
							hit_toggle[event_input_control[e*8 +: 5]] | ev_rise[e];
					default:
						follow_en[0] = follow_en[0];
				endcase
			end
		end
	end

	wire [31:0] ev_apply;
	wire [31:0] ev_level;
	genvar g;
	generate
		for (g = 0; g < `NUM_PINS; g = g + 1)
		begin : pin_res
			event_pin_resolver u_res
			(
				.cur_level (level[g]),
				.hit_set   (hit_set[g]),
				.hit_clear (hit_clear[g]),
				.hit_toggle(hit_toggle[g]),
				.apply     (ev_apply[g]),
				.new_level (ev_level[g])
			);
		end
	endgenerate

	// ------------------------------------------------------------
	// register file
	// ------------------------------------------------------------
	wire [31:0] next_level = (do_wr && sel == SEL_LEVEL)
	                       ? apply_op(level, wdata, op, vis)
	                       : level;
	integer p;

	always @(posedge mclk)
	begin
		if (reset)
		begin
			drive_enable         <= `RST_WORD;
			level                <= `RST_WORD;
			pad_security_attr    <= `RST_WORD;
			security_shadow_copy <= `RST_WORD;
			pad_config_reg       <= {`NUM_PINS{`RST_CFG}};
			pad_function_select  <= {`NUM_PINS{`RST_FUNC}};
			irq_enable           <= 1'b0;
			irq_flag_reg         <= 1'b0;
			sample               <= `RST_WORD;
		end
		else
		begin
			sample <= pad_in;
			if (do_wr && sel == SEL_DIR)
				drive_enable <= apply_op(drive_enable, wdata, op, vis);
			// event pulses land on the third clock edge after the raw edge
			level <= (next_level & ~ev_apply) | (ev_level & ev_apply);
			if (do_wr && sec && sel == SEL_ATTR)
				pad_security_attr <= wdata;
			if (do_wr && sel == SEL_SHADOW)
				security_shadow_copy <= wdata;
			if (do_wr && sel == SEL_IRQEN && sec)
				irq_enable <= wdata[0];
			if (do_wr && sel == SEL_CFG && pin_ok)
				pad_config_reg[pin*3 +: 3] <= wdata[2:0];
			if (do_wr && sel == SEL_FUNC && pin_ok)
				pad_function_select[pin*4 +: 4] <= wdata[3:0];
			// bulk: [31:16] pin mask, [15] cfg, [14] func, [6:4] cfg, [3:0] func
			if (do_wr && sel == SEL_BULK)
			begin
				for (p = 0; p < `NUM_PINS; p = p + 1)
				begin
					if (wdata[16 + (p % 16)] && vis[p]
					    && (p / 16) == op[0])
					begin
						if (wdata[15])
							pad_config_reg[p*3 +: 3] <= wdata[6:4];
						if (wdata[14])
							pad_function_select[p*4 +: 4] <= wdata[3:0];
					end
				end
			end
			// set wins over a same-cycle clear
			if (pad_security_attr != security_shadow_copy)
				irq_flag_reg <= 1'b1;
			else if (do_wr && sel == SEL_FLAG && wdata[0])
				irq_flag_reg <= 1'b0;
		end
	end

	assign port_irq = irq_flag_reg & irq_enable;

	// ------------------------------------------------------------
	// pad drive
	// ------------------------------------------------------------
	generate
		for (g = 0; g < `NUM_PINS; g = g + 1)
		begin : pad_drv
			wire ana = pad_config_reg[g*3+`CFG_FUNC_EN] &&
			           pad_function_select[g*4 +: 4] == `ANALOG_FUNC;
			assign pad_analog[g]   = ana;
			assign pad_out[g]      = ana ? 1'b0 :
			                         follow_en[g] ? follow_val[g] :
			                         level[g];
			assign pad_oe[g]       = drive_enable[g] & ~ana;
			assign pad_input_en[g] = pad_config_reg[g*3+`CFG_INPUT_EN] & ~ana;
			assign pad_pull_en[g]  = pad_config_reg[g*3+`CFG_PULL_EN] & ~ana;
		end
	endgenerate

	// ------------------------------------------------------------
	// read path
	// ------------------------------------------------------------
	reg [31:0] rd;
	always @*
	begin
		rd = 32'h0;
		case (sel)
			SEL_DIR:    rd = drive_enable & vis;
			SEL_LEVEL:  rd = level & vis;
			SEL_IN:     rd = sample & vis;
			SEL_ATTR:   rd = pad_security_attr;
			SEL_SHADOW: rd = security_shadow_copy;
			SEL_CFG:    rd = pin_ok ? {29'h0, pad_config_reg[pin*3 +: 3]}
			                        : 32'h0;
			SEL_FUNC:   rd = pin_ok ? {28'h0, pad_function_select[pin*4 +: 4]}
			                        : 32'h0;
			SEL_FLAG:   rd = {31'h0, irq_flag_reg};
			SEL_IRQEN:  rd = {31'h0, irq_enable};
			default:    rd = 32'h0;
		endcase
	end

	always @(posedge mclk)
	begin
		if (reset)
		begin
			apb_rdata <= 32'h0;
			lpb_rdata <= 32'h0;
		end
		else
		begin
			if (use_lpb)
				lpb_rdata <= rd;
			else if (apb_req)
				apb_rdata <= rd;
		end
	end

endmodule

// *** secure_pin_port_events_monitor.sv ***
`timescale 1ns/100ps

module port_monitor
(
	input wire        mclk,
	input wire        reset,
	input wire        apb_req,
	input wire        apb_ready,
	input wire        lpb_req,
	input wire        apb_write,
	input wire [3:0]  apb_sel,
	input wire [31:0] apb_wdata,
	input wire        lpb_write,
	input wire [3:0]  lpb_sel,
	input wire [31:0] lpb_wdata,
	input wire [31:0] apb_rdata,
	input wire [3:0]  event_in,
	input wire [31:0] event_input_control,
	input wire [31:0] pad_out,
	input wire [31:0] pad_oe,
	input wire [31:0] pad_input_en,
	input wire [31:0] pad_pull_en,
	input wire [31:0] pad_analog,
	input wire        port_irq,
	input wire        irq_flag_reg
);
	default clocking @(posedge mclk); endclocking
	default disable iff (reset);

	wire [7:0] ev0 = event_input_control[7:0];
	wire [7:0] ev2 = event_input_control[23:16];
	// a write of one to the flag target on whichever bus is granted
	wire       clr_wr = lpb_req ? (lpb_write && lpb_sel == 4'h8 && lpb_wdata[0])
	                            : (apb_req && apb_write && apb_sel == 4'h8
	                               && apb_wdata[0]);

	// ------------------------------------------------------------
	// event action sequences
	// ------------------------------------------------------------
	sequence set_rise;
		$rose(event_in[0]) && ev0[5] && ev0[7:6] == 2'h1;
	endsequence
	sequence clr_rise;
		$rose(event_in[2]) && ev2[5] && ev2[7:6] == 2'h2;
	endsequence

	ready_yields_a: assert property (apb_ready == !lpb_req)
		else $error("peripheral bus not stalled by local bus");
	rdata_hold_a: assert property (!(apb_req && apb_ready) |=> $stable(apb_rdata))
		else $error("read data moved without access");
	reset_idle_a: assert property ($fell(reset) |->
		{pad_oe, pad_input_en, pad_pull_en, pad_out} == 128'h0)
		else $error("pads not idle after reset");
	analog_dig_a: assert property ((pad_analog & (pad_input_en | pad_pull_en)) == 32'h0)
		else $error("digital feature on analog pad");
	out_follow_a: assert property (ev0[5] && ev0[7:6] == 2'h0 |->
		pad_out[ev0[4:0]] == event_in[0])
		else $error("pin not following event level");
	set_act_a: assert property (set_rise |-> ##[1:3] pad_out[ev0[4:0]])
		else $error("set event late");
	clr_act_a: assert property (clr_rise |-> ##[1:3] !pad_out[ev2[4:0]])
		else $error("clear event late");
	irq_gate_a: assert property (port_irq |-> irq_flag_reg)
		else $error("interrupt without flag");
	flag_clear_a: assert property ($fell(irq_flag_reg) |-> $past(clr_wr))
		else $error("check flag dropped without clear write");
endmodule

bind secure_pin_port_events port_monitor u_port_monitor
(
	.mclk, .reset, .apb_req, .apb_ready, .lpb_req, .apb_write, .apb_sel,
	.apb_wdata, .lpb_write, .lpb_sel, .lpb_wdata, .apb_rdata,
	.event_in, .event_input_control, .pad_out, .pad_oe,
	.pad_input_en, .pad_pull_en, .pad_analog, .port_irq, .irq_flag_reg
);

// *** test_secure_pin_port_events.sv ***
`timescale 1ns/100ps
`define CHK(n, e, v) begin cmp_count = cmp_count + 1; \
	if ((v) !== (e)) begin num_errors = num_errors + 1; \
	$display("BAD %s exp %h got %h", n, e, v); end end

module test_secure_pin_port_events;
	reg          mclk, reset, apb_req, lpb_req, sec, wr;
	reg  [3:0]   sel;
	reg  [1:0]   op;
	reg  [4:0]   pin;
	reg  [31:0]  wd, ctl, rd;
	reg          lsec, lwr;
	reg  [3:0]   lsel;
	reg  [1:0]   lop;
	reg  [4:0]   lpin;
	reg  [31:0]  lwd;
	wire         apb_ready, port_irq, irq_flag_reg;
	wire [3:0]   event_in;
	wire [31:0]  apb_rdata, lpb_rdata, pad_in, pad_out, pad_oe;
	wire [31:0]  pad_input_en, pad_pull_en, pad_analog;
	wire [127:0] pad_function_select;
	integer      num_errors = 0;
	integer      cmp_count = 0;
	integer      a;

	secure_pin_port_events u_secure_pin_port_events
	(
		.mclk, .reset, .apb_req, .apb_secure(sec), .apb_write(wr),
		.apb_sel(sel), .apb_op(op), .apb_wdata(wd), .apb_pin(pin),
		.apb_ready, .apb_rdata, .lpb_req, .lpb_secure(lsec),
		.lpb_write(lwr), .lpb_sel(lsel), .lpb_op(lop), .lpb_wdata(lwd),
		.lpb_pin(lpin), .lpb_rdata, .event_in, .event_input_control(ctl),
		.pad_in, .pad_out, .pad_oe, .pad_input_en, .pad_pull_en,
		.pad_analog, .pad_function_select, .port_irq, .irq_flag_reg
	);

	pad_event_source u_pad_event_source
	(
		.mclk, .pad_out, .pad_oe, .event_in, .pad_in
	);

	// ------------------------------------------------------------
	// bus helpers
	// ------------------------------------------------------------
	task cyc(input integer n);
	begin
		repeat (n) @(posedge mclk);
		#1;
	end
	endtask

	task acc(input l, s, w, input [3:0] t, input [1:0] o,
		input [31:0] d, input [4:0] p);
	begin
		sec = s;
		wr = w;
		sel = t;
		op = o;
		wd = d;
		pin = p;
		lsec = s;
		lwr = w;
		lsel = t;
		lop = o;
		lwd = d;
		lpin = p;
		if (l)
			lpb_req = 1'b1;
		else
			apb_req = 1'b1;
		@(posedge mclk);
		while (!l && !apb_ready) @(posedge mclk);
		#1;
		apb_req = 1'b0;
		lpb_req = 1'b0;
		rd = l ? lpb_rdata : apb_rdata;
		// one idle edge so the next request never rises in this step
		@(posedge mclk);
		#1;
	end
	endtask

	task wrap_up;
	begin
		if (num_errors == 0 && cmp_count > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	end
	endtask

	// ------------------------------------------------------------
	// scenarios
	// ------------------------------------------------------------
	task t_secure;
	begin
		acc(0, 1, 1, 3, 0, 32'h0000FFFF, 0);
		acc(0, 1, 1, 4, 0, 32'h0000FFFF, 0);
		acc(0, 0, 1, 0, 0, 32'hFFFFFFFF, 0);
		`CHK("dir", 32'h0000FFFF, pad_oe)
		acc(0, 0, 1, 1, 1, 32'hFFFFFFFF, 0);
		`CHK("set", 32'h0000FFFF, pad_out)
		acc(0, 0, 1, 1, 3, 32'hFFFF00FF, 0);
		`CHK("tgl", 32'h0000FF00, pad_out)
		acc(0, 1, 1, 1, 1, 32'hFFFF0000, 0);
		acc(1, 0, 1, 1, 2, 32'hFFFFFFFF, 0);
		`CHK("clr", 32'hFFFF0000, pad_out)
		acc(0, 0, 0, 1, 0, 0, 0);
		`CHK("ns lvl", 32'h0, rd)
		acc(1, 1, 0, 1, 0, 0, 0);
		`CHK("s lvl", 32'hFFFF0000, rd)
		acc(0, 0, 0, 2, 0, 0, 0);
		`CHK("ns in", 32'h0, rd)
	end
	endtask

	task t_cfg;
	begin
		acc(0, 0, 1, 5, 0, 32'h6, 20);
		acc(0, 0, 1, 5, 0, 32'h6, 5);
		`CHK("cfg", 3'b011, {pad_input_en[20], pad_input_en[5], pad_pull_en[5]})
		acc(0, 0, 1, 7, 1, 32'hFFFF8020, 0);
		acc(0, 0, 1, 7, 0, 32'hFFFF8020, 0);
		`CHK("bulk", 32'h0000FFFF, pad_input_en)
		acc(0, 1, 1, 5, 0, 32'h2, 20);
		acc(0, 0, 0, 5, 0, 0, 20);
		`CHK("ns cfg", 32'h0, rd)
		acc(0, 1, 1, 6, 0, 32'h1, 3);
		acc(0, 1, 1, 5, 0, 32'h3, 3);
		`CHK("analog", 6'h21, {pad_analog[3], pad_input_en[3], pad_function_select[15:12]})
	end
	endtask

	task t_flag;
	begin
		acc(0, 0, 1, 8, 0, 32'h1, 0);
		`CHK("chk idle", 1'b0, irq_flag_reg)
		acc(0, 1, 1, 9, 0, 32'h1, 0);
		acc(0, 1, 1, 3, 0, 32'h0000FF00, 0);
		cyc(1);
		`CHK("chk set", 2'b11, {irq_flag_reg, port_irq})
		acc(0, 0, 1, 8, 0, 32'h1, 0);
		cyc(1);
		`CHK("chk held", 1'b1, irq_flag_reg)
		acc(0, 0, 0, 3, 0, 0, 0);
		acc(0, 0, 1, 4, 0, rd, 0);
		acc(0, 0, 1, 8, 0, 32'h1, 0);
		cyc(1);
		`CHK("chk clr", 2'b00, {irq_flag_reg, port_irq})
	end
	endtask

	task t_contend;
	begin
		sec = 1'b1;
		wr = 1'b1;
		sel = 4'h1;
		op = 2'h1;
		wd = 32'h00000100;
		lsec = 1'b1;
		lwr = 1'b1;
		lsel = 4'h1;
		lop = 2'h1;
		lwd = 32'h00000200;
		apb_req = 1'b1;
		lpb_req = 1'b1;
		cyc(1);
		`CHK("stall", 1'b0, apb_ready)
		`CHK("lpb first", 2'b10, {pad_out[9], pad_out[8]})
		lpb_req = 1'b0;
		cyc(1);
		apb_req = 1'b0;
		`CHK("late", 1'b1, pad_out[8])
	end
	endtask

	task t_events;
	begin
		ctl = 32'h00000021;
		u_pad_event_source.put(4'h1);
		#0.1 `CHK("ev out", 1'b1, pad_out[1])
		u_pad_event_source.put(4'h0);
		#0.1 `CHK("ev out", 1'b0, pad_out[1])
		cyc(1);
		acc(0, 1, 1, 1, 0, 32'h00001000, 0);
		for (a = 1; a < 4; a = a + 1)
		begin
			ctl = (32'h20 | a << 6 | (a + 10)) << (8 * a);
			u_pad_event_source.put(4'h1 << a);
			cyc(3);
			`CHK("ev act", a != 2, pad_out[a + 10])
			u_pad_event_source.put(4'h0);
			cyc(1);
		end
		ctl = 32'hCD000000;
		u_pad_event_source.put(4'h8);
		cyc(3);
		`CHK("ev off", 1'b1, pad_out[13])
		u_pad_event_source.put(4'h0);
		cyc(1);
		ctl = 32'hE900A969;
		u_pad_event_source.put(4'hB);
		cyc(3);
		`CHK("ev all", 1'b1, pad_out[9])
		u_pad_event_source.put(4'h0);
		cyc(1);
		ctl = 32'hE900A949;
		u_pad_event_source.put(4'hA);
		cyc(3);
		`CHK("ev prio", 1'b0, pad_out[9])
		u_pad_event_source.put(4'h0);
		cyc(1);
		u_pad_event_source.put(4'hA);
		cyc(3);
		`CHK("ev prio low", 1'b0, pad_out[9])
	end
	endtask

	initial
	begin
		mclk = 1'b0;
		forever #5 mclk = ~mclk;
	end

	// about 90 cycles of work; over twenty times that is a hang
	initial
	begin
		#20000;
		num_errors = num_errors + 1;
		wrap_up;
	end

	initial
	begin
		reset = 1'b1;
		{apb_req, lpb_req, sec, wr, sel, op, pin} = 15'h0;
		{lsec, lwr, lsel, lop, lpin} = 13'h0;
		lwd = 32'h0;
		wd = 32'h0;
		ctl = 32'h0;
		rd = 32'h0;
		repeat (3) @(posedge mclk);
		#1 reset = 1'b0;
		`CHK("idle", 128'h0, {pad_oe, pad_input_en, pad_pull_en, pad_out})
		t_secure;
		t_cfg;
		t_flag;
		t_contend;
		t_events;
		wrap_up;
	end
endmodule
